// File: verilog/ssm_pkg.sv
// ****************************************************************
// Register map, field positions and reset values.
// ****************************************************************
package ssm_pkg;

  // Register offsets on the 8-bit register address port.
  localparam logic [7:0] SSM_OFF_IRQ_FLAGS = 8'h0C;  // peripheral_irq_flags.
  localparam logic [7:0] SSM_OFF_RX_CTRL   = 8'h18;  // receive_status_control.
  localparam logic [7:0] SSM_OFF_TX_BUF    = 8'h19;  // transmit_buffer.
  localparam logic [7:0] SSM_OFF_RX_DATA   = 8'h1A;  // receive_fifo_data.
  localparam logic [7:0] SSM_OFF_IRQ_EN    = 8'h8C;  // peripheral_irq_enables.
  localparam logic [7:0] SSM_OFF_TX_CTRL   = 8'h98;  // transmit_status_control.
  localparam logic [7:0] SSM_OFF_BAUD      = 8'h99;  // baud_divisor.

  // Bit positions in the flag and enable registers.
  localparam int SSM_B_RX_READY = 5;  // Receive data ready flag and enable.
  localparam int SSM_B_TX_EMPTY = 4;  // Transmit buffer empty flag and enable.

  // Bit positions in receive_status_control.
  localparam int SSM_B_SERIAL_PORT_ENABLE  = 7;  // Serial port enable.
  localparam int SSM_B_RX9   = 6;  // Nine-bit receive mode.
  localparam int SSM_B_SINGLE_RECEIVE_EN  = 5;  // Single receive enable.
  localparam int SSM_B_CONTINUOUS_RECEIVE_EN  = 4;  // Continuous receive enable.
  localparam int SSM_B_ADDRESS_DETECT_EN  = 3;  // Address detect enable, stored only.
  localparam int SSM_B_FRAMING_ERROR  = 2;  // Framing error, always zero here.
  localparam int SSM_B_OVERRUN_ERROR  = 1;  // Overrun error.
  localparam int SSM_B_RX_NINTH_BIT  = 0;  // Ninth bit of the FIFO head.

  // Bit positions in transmit_status_control.
  localparam int SSM_B_CLOCK_SOURCE_INTERNAL  = 7;  // Internal clock source, master.
  localparam int SSM_B_TX9   = 6;  // Nine-bit transmit mode.
  localparam int SSM_B_TRANSMIT_ENABLE  = 5;  // Transmit enable.
  localparam int SSM_B_SYNC  = 4;  // Synchronous mode select.
  localparam int SSM_B_HIGH_SPEED_BAUD_SEL  = 2;  // High speed baud select, stored only.
  localparam int SSM_B_SHIFTER_EMPTY_STATUS  = 1;  // Shift register empty status.
  localparam int SSM_B_TX_NINTH_BIT  = 0;  // Ninth transmit bit.

  // Reset value of transmit_status_control, shift register empty.
  localparam logic [7:0] SSM_TX_CTRL_RST = 8'h02;

  // Word lengths in bits, sized to the bit counters.
  localparam logic [3:0] SSM_LEN8 = 4'h8;
  localparam logic [3:0] SSM_LEN9 = 4'h9;

  // Depth of the receive FIFO.
  localparam logic [1:0] SSM_FIFO_DEPTH = 2'h2;

endpackage

// File: verilog/ssm_top.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns

module ssm_top
  import ssm_pkg::*;
(
  input  wire logic       sys_clk,     // System clock, 25 MHz.
  input  wire logic       rst_b,       // Asynchronous reset, active low.
  input  wire logic [7:0] reg_addr,    // Register address.
  input  wire logic [7:0] reg_wdata,   // Register write data.
  input  wire logic       reg_wr,      // Write strobe.
  input  wire logic       reg_rd,      // Read strobe.
  output logic      [7:0] reg_rdata,   // Read data, valid the cycle after the strobe.
  output logic            irq,         // Interrupt request, level.
  input  wire logic       ck_i,        // Shift clock pin level, unused in every mode.
  output logic            ck_o,        // Shift clock pin drive value.
  output logic            ck_oe,       // Shift clock pin output enable.
  input  wire logic       dt_i,        // Serial data pin level.
  output logic            dt_o,        // Serial data pin drive value.
  output logic            dt_oe        // Serial data pin output enable.
);

  // ****************************************************************
  // State of the block.
  // ****************************************************************

  // All state lives in one packed struct so that a single process registers it.
  typedef struct packed {
    logic            dt_s1;        // First synchroniser stage of the data pin.
    logic            dt_s2;        // Second synchroniser stage of the data pin.
    logic            ck_lvl;       // Shift clock level.
    logic            ck_oe;        // Clock pin enable.
    logic            dt_o;         // Data pin value.
    logic            dt_oe;        // Data pin enable.
    logic            irq;          // Interrupt output.
    logic [7:0]      brg_cnt;      // Baud generator down counter.
    logic [7:0]      divisor;      // baud_divisor contents.
    logic            clock_source_internal;         // Internal clock source.
    logic            tx9;          // Nine-bit transmit.
    logic            transmit_enable;         // Transmit enable.
    logic            sync;         // Synchronous mode.
    logic            high_speed_baud_sel;         // High speed select, stored only.
    logic            tx_ninth_bit;         // Ninth transmit bit.
    logic            serial_port_enable;         // Serial port enable.
    logic            rx9;          // Nine-bit receive.
    logic            single_receive_en;         // Single receive enable.
    logic            continuous_receive_en;         // Continuous receive enable.
    logic            address_detect_en;         // Address detect, stored only.
    logic            overrun_error;         // Overrun error.
    logic            tx_buffer_empty_irq_en;         // Buffer empty interrupt enable.
    logic            rx_data_ready_irq_en;         // Receive interrupt enable.
    logic            tx_buffer_empty_flag;         // Buffer empty flag.
    logic [7:0]      txbuf;        // transmit_buffer contents.
    logic            buf_full;     // Buffer holds an untransferred word.
    logic [8:0]      tx_shift_reg;          // Transmit shift register.
    logic            tx_act;       // Shift register holds a word.
    logic [3:0]      tx_cnt;       // Bits driven of the current word.
    logic [8:0]      rx_shift_reg;          // Receive shift register.
    logic [3:0]      rx_cnt;       // Bits sampled of the current word.
    logic [1:0][8:0] fifo;         // Receive FIFO, ninth bit in bit 8.
    logic            fifo_rd;      // FIFO head index.
    logic [1:0]      fifo_cnt;     // FIFO fill level.
    logic [7:0]      rdata;        // Registered read data.
  } ssm_state_s;

  ssm_state_s st_r;                // Registered state.
  ssm_state_s st_nxt;              // Next state.

  // Outputs come straight from the state flip-flops.
  assign reg_rdata = st_r.rdata;
  assign irq       = st_r.irq;
  assign ck_o      = st_r.ck_lvl;
  assign ck_oe     = st_r.ck_oe;
  assign dt_o      = st_r.dt_o;
  assign dt_oe     = st_r.dt_oe;

  // Register hit decode, shared by the read and the write paths.
  function automatic logic ssm_hit(input logic [7:0] addr, input logic [7:0] off);
    ssm_hit = (addr == off);
  endfunction

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************

  // Software writes are applied first, so hardware events below win over them.
  always_comb begin
    logic       brg_run;
    logic       rx_run;
    logic       tx_run;
    logic       tick;
    logic       rise;
    logic       fall;
    logic       done;
    logic       wr_tx;
    logic       push;
    logic       pop;
    logic [3:0] tx_len;
    logic [3:0] rx_len;
    logic [8:0] rx_word;
    logic       wr_idx;
    st_nxt  = st_r;
    brg_run = 1'b0;
    rx_run  = 1'b0;
    tx_run  = 1'b0;
    tick    = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    done    = 1'b0;
    push    = 1'b0;
    pop     = 1'b0;
    rx_word = 9'h000;
    wr_idx  = 1'b0;
    wr_tx   = reg_wr && ssm_hit(reg_addr, SSM_OFF_TX_BUF);
    tx_len  = st_r.tx9 ? SSM_LEN9 : SSM_LEN8;
    rx_len  = st_r.rx9 ? SSM_LEN9 : SSM_LEN8;

    // Data pin synchroniser; the first stage feeds only the second.
    st_nxt.dt_s1 = dt_i;
    st_nxt.dt_s2 = st_r.dt_s1;

    // Register writes.
    if (reg_wr) begin
      if (ssm_hit(reg_addr, SSM_OFF_RX_CTRL)) begin
        st_nxt.serial_port_enable = reg_wdata[SSM_B_SERIAL_PORT_ENABLE];
        st_nxt.rx9  = reg_wdata[SSM_B_RX9];
        st_nxt.single_receive_en = reg_wdata[SSM_B_SINGLE_RECEIVE_EN];
        st_nxt.continuous_receive_en = reg_wdata[SSM_B_CONTINUOUS_RECEIVE_EN];
        st_nxt.address_detect_en = reg_wdata[SSM_B_ADDRESS_DETECT_EN];
        // Only a write that clears continuous receive clears overrun.
        if (!reg_wdata[SSM_B_CONTINUOUS_RECEIVE_EN]) begin
          st_nxt.overrun_error = 1'b0;
        end
      end
      if (ssm_hit(reg_addr, SSM_OFF_TX_CTRL)) begin
        st_nxt.clock_source_internal = reg_wdata[SSM_B_CLOCK_SOURCE_INTERNAL];
        st_nxt.tx9  = reg_wdata[SSM_B_TX9];
        st_nxt.transmit_enable = reg_wdata[SSM_B_TRANSMIT_ENABLE];
        st_nxt.sync = reg_wdata[SSM_B_SYNC];
        st_nxt.high_speed_baud_sel = reg_wdata[SSM_B_HIGH_SPEED_BAUD_SEL];
        st_nxt.tx_ninth_bit = reg_wdata[SSM_B_TX_NINTH_BIT];
      end
      if (ssm_hit(reg_addr, SSM_OFF_IRQ_EN)) begin
        st_nxt.tx_buffer_empty_irq_en = reg_wdata[SSM_B_TX_EMPTY];
        st_nxt.rx_data_ready_irq_en = reg_wdata[SSM_B_RX_READY];
      end
      if (ssm_hit(reg_addr, SSM_OFF_BAUD)) begin
        st_nxt.divisor = reg_wdata;
      end
      // A buffer write fills the buffer and is the only thing that clears the flag.
      if (wr_tx) begin
        st_nxt.txbuf    = reg_wdata;
        st_nxt.buf_full = 1'b1;
        st_nxt.tx_buffer_empty_flag     = 1'b0;
      end
    end

    // Baud generator: one clock edge every divisor+1 cycles, held in reset when idle.
    brg_run = st_r.serial_port_enable && st_r.sync && (st_r.transmit_enable || st_r.continuous_receive_en || st_r.single_receive_en);
    if (!brg_run) begin
      st_nxt.brg_cnt = 8'h00;
      st_nxt.ck_lvl  = 1'b0;
    end else if (st_r.brg_cnt == 8'h00) begin
      // A fresh start hits zero at once, so the first edge is immediate.
      tick           = 1'b1;
      st_nxt.brg_cnt = st_r.divisor;
      st_nxt.ck_lvl  = !st_r.ck_lvl;
    end else begin
      st_nxt.brg_cnt = st_r.brg_cnt - 8'h01;
    end
    rise = tick && !st_r.ck_lvl;
    fall = tick && st_r.ck_lvl;

    // Either receive enable takes the port away from the transmitter.
    rx_run = st_r.serial_port_enable && st_r.sync && (st_r.continuous_receive_en || st_r.single_receive_en);
    tx_run = st_r.serial_port_enable && st_r.sync && st_r.transmit_enable && !rx_run;

    // Transmitter.
    if (!st_r.transmit_enable) begin
      // Clearing the enable aborts and resets the shifter; the buffer keeps its word.
      st_nxt.tx_act = 1'b0;
      st_nxt.tx_cnt = 4'h0;
    end else if (tx_run) begin
      // Data changes only on a rising clock edge, so it is stable at the falling one.
      if (rise && st_r.tx_act) begin
        if (st_r.tx_cnt == tx_len) begin
          // The last bit has had its falling edge; the shifter is now empty.
          st_nxt.tx_act = 1'b0;
          done          = 1'b1;
        end else begin
          st_nxt.dt_o   = st_r.tx_shift_reg[0];
          st_nxt.tx_shift_reg    = {1'b0, st_r.tx_shift_reg[8:1]};
          st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
        end
      end
      // Buffer to shifter transfer in a single cycle, whenever the shifter is empty.
      if (st_r.buf_full && (!st_r.tx_act || done)) begin
        st_nxt.tx_shift_reg      = {st_r.tx_ninth_bit, st_r.txbuf};
        st_nxt.tx_act   = 1'b1;
        st_nxt.tx_cnt   = 4'h0;
        st_nxt.buf_full = wr_tx;
        st_nxt.tx_buffer_empty_flag     = !wr_tx;
        // On the edge that ends a word the next first bit goes out at once.
        if (done) begin
          st_nxt.dt_o   = st_r.txbuf[0];
          st_nxt.tx_shift_reg    = {1'b0, st_r.tx_ninth_bit, st_r.txbuf[7:1]};
          st_nxt.tx_cnt = 4'h1;
        end
      end
    end
    // While receiving the transmitter simply holds; it is not reset.

    // Receiver: sample the synchronised data on each falling clock edge.
    if (!rx_run) begin
      st_nxt.rx_cnt = 4'h0;
    end else if (fall) begin
      if (st_r.rx9) begin
        rx_word = {st_r.dt_s2, st_r.rx_shift_reg[8:1]};
      end else begin
        rx_word = {1'b0, st_r.dt_s2, st_r.rx_shift_reg[7:1]};
      end
      st_nxt.rx_shift_reg    = rx_word;
      st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
      if (st_r.rx_cnt + 4'h1 == rx_len) begin
        st_nxt.rx_cnt = 4'h0;
        // Single receive ends itself unless continuous receive is also set.
        if (st_r.single_receive_en && !st_r.continuous_receive_en) begin
          st_nxt.single_receive_en = 1'b0;
        end
        // Overrun blocks every transfer; a full FIFO raises overrun and drops the word.
        if (!st_r.overrun_error) begin
          if (st_r.fifo_cnt == SSM_FIFO_DEPTH) begin
            st_nxt.overrun_error = 1'b1;
          end else begin
            push = 1'b1;
          end
        end
      end
    end

    // Register reads; unmapped addresses read zero.
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      if (ssm_hit(reg_addr, SSM_OFF_IRQ_FLAGS)) begin
        st_nxt.rdata[SSM_B_RX_READY] = (st_r.fifo_cnt != 2'h0);
        st_nxt.rdata[SSM_B_TX_EMPTY] = st_r.tx_buffer_empty_flag;
      end
      if (ssm_hit(reg_addr, SSM_OFF_RX_CTRL)) begin
        st_nxt.rdata[SSM_B_SERIAL_PORT_ENABLE] = st_r.serial_port_enable;
        st_nxt.rdata[SSM_B_RX9]  = st_r.rx9;
        st_nxt.rdata[SSM_B_SINGLE_RECEIVE_EN] = st_r.single_receive_en;
        st_nxt.rdata[SSM_B_CONTINUOUS_RECEIVE_EN] = st_r.continuous_receive_en;
        st_nxt.rdata[SSM_B_ADDRESS_DETECT_EN] = st_r.address_detect_en;
        st_nxt.rdata[SSM_B_FRAMING_ERROR] = 1'b0;
        st_nxt.rdata[SSM_B_OVERRUN_ERROR] = st_r.overrun_error;
        st_nxt.rdata[SSM_B_RX_NINTH_BIT] = st_r.fifo[st_r.fifo_rd][8];
      end
      if (ssm_hit(reg_addr, SSM_OFF_TX_BUF)) begin
        st_nxt.rdata = st_r.txbuf;
      end
      if (ssm_hit(reg_addr, SSM_OFF_RX_DATA)) begin
        st_nxt.rdata = st_r.fifo[st_r.fifo_rd][7:0];
        pop          = (st_r.fifo_cnt != 2'h0);
      end
      if (ssm_hit(reg_addr, SSM_OFF_IRQ_EN)) begin
        st_nxt.rdata[SSM_B_RX_READY] = st_r.rx_data_ready_irq_en;
        st_nxt.rdata[SSM_B_TX_EMPTY] = st_r.tx_buffer_empty_irq_en;
      end
      if (ssm_hit(reg_addr, SSM_OFF_TX_CTRL)) begin
        st_nxt.rdata[SSM_B_CLOCK_SOURCE_INTERNAL] = st_r.clock_source_internal;
        st_nxt.rdata[SSM_B_TX9]  = st_r.tx9;
        st_nxt.rdata[SSM_B_TRANSMIT_ENABLE] = st_r.transmit_enable;
        st_nxt.rdata[SSM_B_SYNC] = st_r.sync;
        st_nxt.rdata[SSM_B_HIGH_SPEED_BAUD_SEL] = st_r.high_speed_baud_sel;
        st_nxt.rdata[SSM_B_SHIFTER_EMPTY_STATUS] = !st_r.tx_act;
        st_nxt.rdata[SSM_B_TX_NINTH_BIT] = st_r.tx_ninth_bit;
      end
      if (ssm_hit(reg_addr, SSM_OFF_BAUD)) begin
        st_nxt.rdata = st_r.divisor;
      end
    end

    // FIFO update; a push and a pop in the same cycle leave the level unchanged.
    wr_idx = st_r.fifo_rd ^ st_r.fifo_cnt[0];
    if (push) begin
      st_nxt.fifo[wr_idx] = rx_word;
    end
    if (pop) begin
      st_nxt.fifo_rd = !st_r.fifo_rd;
    end
    case ({push, pop})
      2'b10:   st_nxt.fifo_cnt = st_r.fifo_cnt + 2'h1;
      2'b01:   st_nxt.fifo_cnt = st_r.fifo_cnt - 2'h1;
      default: st_nxt.fifo_cnt = st_r.fifo_cnt;
    endcase

    // Interrupt request from flags gated by their enables.
    st_nxt.irq = (st_nxt.tx_buffer_empty_flag && st_nxt.tx_buffer_empty_irq_en) ||
                 ((st_nxt.fifo_cnt != 2'h0) && st_nxt.rx_data_ready_irq_en);

    // Pin enables from the next configuration, so they follow writes promptly.
    st_nxt.ck_oe = st_nxt.serial_port_enable && st_nxt.sync && st_nxt.clock_source_internal &&
                   (st_nxt.transmit_enable || st_nxt.continuous_receive_en || st_nxt.single_receive_en);
    // The data pin drives only while transmitting; it returns as soon as a
    // single receive ends with transmit still enabled.
    st_nxt.dt_oe = st_nxt.serial_port_enable && st_nxt.sync && st_nxt.transmit_enable &&
                   !(st_nxt.continuous_receive_en || st_nxt.single_receive_en);
  end

  // ****************************************************************
  // State register.
  // ****************************************************************

  // Reset loads constants only; the shifter-empty status starts set.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r      <= '0;
      st_r.high_speed_baud_sel <= SSM_TX_CTRL_RST[SSM_B_HIGH_SPEED_BAUD_SEL];
      st_r.tx_ninth_bit <= SSM_TX_CTRL_RST[SSM_B_TX_NINTH_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// File: dv/ssm_asserts.sv
`timescale 1ns/1ns
// ****
// Shift clock and data pin checks.
// ****
module ssm_asserts
  import ssm_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       ck_o,
  input wire logic       ck_oe,
  input wire logic       dt_o,
  input wire logic       dt_oe
);
  logic [7:0] div_r;  // Shadow of the baud divisor.
  logic [8:0] hi_r;   // Cycles the clock has stood high.
  logic [8:0] lo_r;   // Cycles the clock has stood low.
  logic [8:0] half;   // Expected half period.
  assign half = {1'b0, div_r} + 9'h001;
  // Divisor changes while the clock runs are not modelled.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 8'h00;
      hi_r  <= 9'h000;
      lo_r  <= 9'h000;
    end else begin
      if (reg_wr && reg_addr == SSM_OFF_BAUD) begin
        div_r <= reg_wdata;
      end
      hi_r <= ck_o ? hi_r + 9'h001 : 9'h000;
      lo_r <= ck_o ? 9'h000 : lo_r + 9'h001;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_ck_start;
    $rose(ck_oe);
  endsequence
  sequence s_ck_off;
    !ck_oe [*2];
  endsequence
  AST_CK_DRIVEN: assert property ($rose(ck_o) |-> ck_oe)
    else $error("clock toggled while not driven");
  AST_CK_HIGH: assert property ($fell(ck_o) && ck_oe |-> hi_r == half)
    else $error("clock high time wrong");
  AST_CK_LOW: assert property ($rose(ck_o) && $past(ck_oe, 2) |-> lo_r == half)
    else $error("clock low time wrong");
  AST_DT_ON_RISE: assert property (dt_oe && $past(dt_oe) && $changed(dt_o) |-> $rose(ck_o))
    else $error("data changed away from rising clock");
  AST_DT_WITH_CK: assert property (dt_oe |-> ck_oe)
    else $error("data driven without clock");
  AST_PINS_OFF: assert property ($fell(ck_oe) |-> !dt_oe)
    else $error("data still driven after clock released");
  AST_CK_START: assert property (s_ck_start |-> ##[0:1] $rose(ck_o))
    else $error("clock did not start at once");
  AST_CK_IDLE: assert property (s_ck_off |-> !ck_o)
    else $error("stopped clock not low");
endmodule
bind ssm_top ssm_asserts u_chk (
  .sys_clk   (sys_clk),
  .rst_b     (rst_b),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .ck_o      (ck_o),
  .ck_oe     (ck_oe),
  .dt_o      (dt_o),
  .dt_oe     (dt_oe)
);

// File: dv/ssm_slave.sv
`timescale 1ns/1ns
// ****
// External synchronous slave on the far side of the pins.
// ****
module ssm_slave (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        ck,     // Clock line level.
  input  wire logic        dt,     // Data line level.
  input  wire logic        dt_own, // High while the master drives data.
  input  wire logic        load,   // Takes a new bit stream.
  input  wire logic [31:0] word,   // Bits to send, first bit at bit 0.
  input  wire logic [5:0]  nbits,  // Number of bits to send.
  output logic             s_do,   // Slave data drive value.
  output logic      [31:0] cap     // Heard bits, newest at the top.
);
  logic        ck_d;  // Clock one cycle ago.
  logic [31:0] bits;  // Bits still to send.
  logic [5:0]  left;  // Count of bits still to send.
  logic        fell;  // A falling edge was seen since loading.
  logic        tog;   // Pattern shown on a released line.
  // A released line must not look like a held bit, so it toggles.
  assign s_do = (left != 6'h00) ? bits[0] : tog;
  // Data moves on the rising edge, away from the falling sample.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ck_d <= 1'b0;
      bits <= 32'h0;
      left <= 6'h00;
      fell <= 1'b0;
      tog  <= 1'b0;
      cap  <= 32'h0;
    end else begin
      ck_d <= ck;
      tog  <= !tog;
      if (load) begin
        bits <= word;
        left <= nbits;
        fell <= 1'b0;
      end else if (ck && !ck_d && fell && left != 6'h00) begin
        bits <= bits >> 1;
        left <= left - 6'h01;
      end
      if (!ck && ck_d) begin
        fell <= 1'b1;
        if (dt_own) begin
          cap <= {dt, cap[31:1]};
        end
      end
    end
  end
endmodule

// File: dv/tb.sv
`timescale 1ns/1ns
module tb
  import ssm_pkg::*;
;
  logic        sys_clk, rst_b, reg_wr, reg_rd, irq, ck_o, ck_oe, dt_o, dt_oe;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
  logic        s_load, s_do, ck_w, dt_w;
  logic [31:0] s_word, cap;
  logic [5:0]  s_nbits;
  int          n_fail, check_count, cyc;
  // The clock line carries a weak pull-down while nobody drives it.
  assign ck_w = ck_oe & ck_o;
  assign dt_w = dt_oe ? dt_o : s_do;
  always #20 sys_clk = ~sys_clk;
  ssm_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .ck_i(ck_w), .ck_o(ck_o), .ck_oe(ck_oe), .dt_i(dt_w), .dt_o(dt_o),
    .dt_oe(dt_oe));
  ssm_slave slave_u (.sys_clk(sys_clk), .rst_b(rst_b), .ck(ck_w), .dt(dt_w),
    .dt_own(dt_oe), .load(s_load), .word(s_word), .nbits(s_nbits), .s_do(s_do),
    .cap(cap));
  // ****
  // Shared tasks.
  // ****
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // Loads the slave just after a rising edge while the clock is driven, at once otherwise; its first bit waits for the next fall.
  task automatic sload(input logic [31:0] w, input logic [5:0] n);
    if (ck_oe) begin
      @(posedge ck_o);
    end
    s_word  <= w;
    s_nbits <= n;
    s_load  <= 1'b1;
    @(posedge sys_clk);
    s_load <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****
  // Scenarios.
  // ****
  task automatic t_regs();
    logic [7:0] offs [8];
    logic [7:0] rstv [8];
    offs = '{SSM_OFF_IRQ_FLAGS, SSM_OFF_RX_CTRL, SSM_OFF_TX_BUF, SSM_OFF_RX_DATA,
             SSM_OFF_IRQ_EN, SSM_OFF_TX_CTRL, SSM_OFF_BAUD, 8'h55};
    rstv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, SSM_TX_CTRL_RST, 8'h00, 8'h00};
    wr(8'h55, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      rd(offs[i]);
      chk(rv, rstv[i]);
    end
    wr(SSM_OFF_TX_CTRL, 8'h00);
    rd(SSM_OFF_TX_CTRL);
    chk(rv, SSM_TX_CTRL_RST);
    $display("register test done");
  endtask
  // Two queued 9-bit words, the second with a ninth bit changed while it waits.
  task automatic t_tx();
    logic ok;
    wr(SSM_OFF_BAUD, 8'h03);
    wr(SSM_OFF_RX_CTRL, 8'h80);
    wr(SSM_OFF_IRQ_EN, 8'h10);
    wr(SSM_OFF_TX_CTRL, 8'hF1);
    wr(SSM_OFF_TX_BUF, 8'hA5);
    rd(SSM_OFF_IRQ_FLAGS);
    chk(rv, 8'h10);
    chk({7'h00, irq}, 8'h01);
    wr(SSM_OFF_TX_BUF, 8'h3C);
    rd(SSM_OFF_IRQ_FLAGS);
    chk(rv, 8'h00);
    rd(SSM_OFF_TX_CTRL);
    chk(rv, 8'hF1);
    wr(SSM_OFF_TX_CTRL, 8'hF0);
    repeat (170) @(posedge sys_clk);
    ok = 1'b0;
    for (int k = 0; k < 15; k++) begin
      if (cap[k +: 18] === {1'b0, 8'h3C, 1'b1, 8'hA5}) begin
        ok = 1'b1;
      end
    end
    chk({7'h00, ok}, 8'h01);
    rd(SSM_OFF_TX_CTRL);
    chk(rv, 8'hF2);
    wr(SSM_OFF_IRQ_FLAGS, 8'h00);
    rd(SSM_OFF_IRQ_FLAGS);
    chk(rv, 8'h10);
    wr(SSM_OFF_TX_CTRL, 8'h90);
    repeat (2) @(posedge sys_clk);
    chk({6'h00, ck_oe, dt_oe}, 8'h00);
    $display("transmit test done");
  endtask
  // Three 9-bit words into a two-deep queue: the third overruns.
  task automatic t_rx();
    wr(SSM_OFF_IRQ_EN, 8'h20);
    sload({5'h00, 9'h177, 9'h0C3, 9'h15A}, 6'd27);
    wr(SSM_OFF_RX_CTRL, 8'hD0);
    repeat (240) @(posedge sys_clk);
    chk({7'h00, irq}, 8'h01);
    rd(SSM_OFF_RX_CTRL);
    chk(rv, 8'hD3);
    wr(SSM_OFF_RX_CTRL, 8'hC0);
    rd(SSM_OFF_RX_CTRL);
    chk(rv, 8'hC1);
    rd(SSM_OFF_RX_DATA);
    chk(rv, 8'h5A);
    rd(SSM_OFF_IRQ_FLAGS);
    chk(rv, 8'h30);
    rd(SSM_OFF_RX_CTRL);
    chk(rv, 8'hC0);
    rd(SSM_OFF_RX_DATA);
    chk(rv, 8'hC3);
    rd(SSM_OFF_IRQ_FLAGS);
    chk(rv, 8'h10);
    chk({7'h00, irq}, 8'h00);
    $display("receive test done");
  endtask
  // A single receive breaks into a running transmission.
  task automatic t_single_receive_en();
    wr(SSM_OFF_RX_CTRL, 8'h80);
    wr(SSM_OFF_TX_CTRL, 8'hB0);
    wr(SSM_OFF_TX_BUF, 8'h0F);
    repeat (24) @(posedge sys_clk);
    // Enable just after a fall, so the first sample sees a whole half period of slave data.
    @(negedge ck_o);
    wr(SSM_OFF_RX_CTRL, 8'hA0);
    sload(32'h96, 6'd8);
    repeat (2) @(posedge sys_clk);
    chk({6'h00, ck_oe, dt_oe}, 8'h02);
    repeat (80) @(posedge sys_clk);
    chk({6'h00, ck_oe, dt_oe}, 8'h03);
    rd(SSM_OFF_RX_CTRL);
    chk(rv, 8'h80);
    rd(SSM_OFF_RX_DATA);
    chk(rv, 8'h96);
    wr(SSM_OFF_TX_CTRL, 8'h90);
    $display("single receive test done");
  endtask
  // A hang counts as a mismatch.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    s_load = 1'b0;
    s_word = 32'h0;
    s_nbits = 6'h00;
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_single_receive_en();
    conclude();
  end
endmodule
